// ===== hdl/capture_interval_timer8.sv
// Contract
// R01: 8-bit counter ticks on selected clock
// R02: counter hidden from bus, resets zero
// R03: pin function picks capture or interval
// R04: overflow sets request when enabled
// R05: falling edge copies count to register
// R06: rising edge copies count to register
// R07: edge select picks interrupting capture edge
// R08: source holds pulses at least two clocks
// R09: high overflow flag set on wrap
// R10: low overflow flag set, interval too
// R11: flags clear by read-one write-zero
// R12: overflow enable gates overflow request
// R13: clear field selects clearing edges
// R14: clock select picks four count clocks
// R15: standby bit halts block, resets one
// R16: five-latch filter updates on agreement
// R17: filter samples system or count clock
// R18: filter primed after five low samples
// R19: short high pulses suppressed when filtered
// R20: mode changes may cause spurious edge
// R21: tick on falling edge of divided clock
// R22: edge strobes from filtered level compare
//
// 8-bit capture and interval timer with APB register access.
// Assumes watchTick is a one-cycle pulse at the watch clock rate, synchronous to clock.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module capture_interval_timer8
    import capture_timer_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic watchTick,
    input wire logic captureIn,
    output logic timerIrq
);
    logic [7:0] captureUpCounter;
    logic [7:0] fallingCaptureValue;
    logic [7:0] risingCaptureValue;
    logic [7:0] moduleClockStopOne;
    logic overflowAtHighFlag;
    logic overflowAtLowFlag;
    logic overflowIrqEnable;
    logic irqEdgeSelect;
    logic [1:0] clearSel;
    logic [1:0] clockSelect;
    logic capturePinFunction;
    logic noiseFilterEnable;
    logic timerIrqEnable;
    logic timerIrqRequestFlag;
    logic highFlagSeen;
    logic lowFlagSeen;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [WATCH_DIV_WIDTH-1:0] watchDiv;
    logic selClock;
    logic selClockDly;
    logic countTick;
    logic sampleEn;
    logic pinLevel;
    logic filtLevel;
    logic filtPrimed;
    logic capLevel;
    logic capLevelDly;
    logic riseStrobe;
    logic fallStrobe;
    logic wrap;
    logic clearHit;
    logic active;
    logic access;
    logic wrMode;
    logic wrPort;
    logic rdMode;
    logic mapped;
    logic [17:0] addr;

    function automatic logic divBit(input logic [1:0] sel,
                                    input logic [PRESCALE_WIDTH-1:0] pre,
                                    input logic [WATCH_DIV_WIDTH-1:0] wd);
        unique case (sel)
            CKS_DIV64: divBit = pre[5];
            CKS_DIV32: divBit = pre[4];
            CKS_DIV2: divBit = pre[0];
            CKS_WATCH4: divBit = wd[1];
        endcase
    endfunction

    assign addr = paddr[17:0];
    assign access = psel && penable;
    assign mapped = addr == ADDR_MODE || addr == ADDR_FALL || addr == ADDR_RISE
        || addr == ADDR_STOP || addr == ADDR_PORT;
    assign wrMode = access && pwrite && pstrb[0] && addr == ADDR_MODE;
    assign wrPort = access && pwrite && pstrb[0] && addr == ADDR_PORT;
    assign rdMode = access && !pwrite && addr == ADDR_MODE;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    // R15: standby stops the block
    assign active = moduleClockStopOne[STANDBY_BIT];

    // R14: dividers, running while not in standby
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prescale <= '0;
            watchDiv <= '0;
        end else if (active) begin
            prescale <= prescale + PRESCALE_WIDTH'(1);
            if (watchTick) begin
                watchDiv <= watchDiv + WATCH_DIV_WIDTH'(1);
            end
        end
    end

    // R21: falling edge of selected clock
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            selClockDly <= 1'b0;
        end else begin
            selClockDly <= selClock;
        end
    end
    assign selClock = divBit(clockSelect, prescale, watchDiv);
    assign countTick = active && selClockDly && !selClock;

    // R17: filter sampling source
    assign sampleEn = active && (noiseFilterEnable ? (!selClockDly && selClock) : 1'b1);
    // R03: pin reads low when not a capture input
    assign pinLevel = capturePinFunction && captureIn;

    noise_filter filter (
        .clock(clock),
        .nrst(nrst),
        .sampleEn(sampleEn),
        .din(pinLevel),
        .dout(filtLevel),
        .primed(filtPrimed)
    );

    // R20: switching filter use is not masked
    assign capLevel = noiseFilterEnable ? filtLevel : pinLevel;

    // R22: edge strobes from level compare
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            capLevelDly <= 1'b0;
        end else if (active) begin
            capLevelDly <= capLevel;
        end
    end
    assign riseStrobe = active && capLevel && !capLevelDly;
    assign fallStrobe = active && !capLevel && capLevelDly;

    // R13: clearing edges, capture mode only
    always_comb begin
        unique case (clearSel)
            CLR_NONE: clearHit = 1'b0;
            CLR_FALL: clearHit = fallStrobe;
            CLR_RISE: clearHit = riseStrobe;
            CLR_BOTH: clearHit = fallStrobe || riseStrobe;
        endcase
        clearHit = clearHit && capturePinFunction;
    end
    assign wrap = countTick && !clearHit && captureUpCounter == 8'hff;

    // R01: counter advances on tick
    // R02: zero at reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            captureUpCounter <= 8'h00;
        end else if (clearHit) begin
            captureUpCounter <= 8'h00;
        end else if (countTick) begin
            captureUpCounter <= captureUpCounter + 8'h01;
        end
    end

    // R05: falling capture
    // R06: rising capture
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fallingCaptureValue <= CAPTURE_RESET;
            risingCaptureValue <= CAPTURE_RESET;
        end else begin
            if (fallStrobe) begin
                fallingCaptureValue <= captureUpCounter;
            end
            if (riseStrobe) begin
                risingCaptureValue <= captureUpCounter;
            end
        end
    end

    // R11: read-as-one arms the clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            highFlagSeen <= 1'b0;
            lowFlagSeen <= 1'b0;
        end else if (rdMode) begin
            // Arm only on the value the reader was actually handed
            highFlagSeen <= prdata[OVF_HIGH_BIT];
            lowFlagSeen <= prdata[OVF_LOW_BIT];
        end else if (wrMode) begin
            highFlagSeen <= 1'b0;
            lowFlagSeen <= 1'b0;
        end
    end

    // R09: high flag, set wins over clear
    // R10: low flag, interval always low
    // R11: one writes ignored
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            overflowAtHighFlag <= 1'b0;
            overflowAtLowFlag <= 1'b0;
        end else begin
            if (wrap && capLevel && capturePinFunction) begin
                overflowAtHighFlag <= 1'b1;
            end else if (wrMode && highFlagSeen && !pwdata[OVF_HIGH_BIT]) begin
                overflowAtHighFlag <= 1'b0;
            end
            if (wrap && !(capLevel && capturePinFunction)) begin
                overflowAtLowFlag <= 1'b1;
            end else if (wrMode && lowFlagSeen && !pwdata[OVF_LOW_BIT]) begin
                overflowAtLowFlag <= 1'b0;
            end
        end
    end

    // Control fields of the mode register and the loose port bits
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            overflowIrqEnable <= MODE_RESET[OVF_IE_BIT];
            irqEdgeSelect <= MODE_RESET[EDGE_SEL_BIT];
            clearSel <= MODE_RESET[CLR_HI_BIT:CLR_LO_BIT];
            clockSelect <= MODE_RESET[CKS_HI_BIT:CKS_LO_BIT];
        end else if (wrMode && active) begin
            overflowIrqEnable <= pwdata[OVF_IE_BIT];
            irqEdgeSelect <= pwdata[EDGE_SEL_BIT];
            clearSel <= pwdata[CLR_HI_BIT:CLR_LO_BIT];
            clockSelect <= pwdata[CKS_HI_BIT:CKS_LO_BIT];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            capturePinFunction <= 1'b0;
            noiseFilterEnable <= 1'b0;
            timerIrqEnable <= 1'b0;
        end else if (wrPort) begin
            capturePinFunction <= pwdata[PORT_PIN_FUNC_BIT];
            noiseFilterEnable <= pwdata[PORT_NOISE_BIT];
            timerIrqEnable <= pwdata[PORT_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            moduleClockStopOne <= STOP_RESET;
        end else if (access && pwrite && pstrb[0] && addr == ADDR_STOP) begin
            moduleClockStopOne <= pwdata[7:0];
        end
    end

    // R04: overflow raises request
    // R07: selected capture edge raises request
    // R12: overflow enable gating
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            timerIrqRequestFlag <= 1'b0;
        end else if ((wrap && overflowIrqEnable)
                || (capturePinFunction && (irqEdgeSelect ? fallStrobe : riseStrobe))) begin
            timerIrqRequestFlag <= 1'b1;
        end else if (wrPort && !pwdata[PORT_IRQ_FLAG_BIT]) begin
            timerIrqRequestFlag <= 1'b0;
        end
    end
    assign timerIrq = timerIrqRequestFlag && timerIrqEnable;

    // Read data registered at the end of the setup phase
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (addr)
                ADDR_MODE: prdata <= {24'h0, overflowAtHighFlag, overflowAtLowFlag,
                    overflowIrqEnable, irqEdgeSelect, clearSel, clockSelect};
                ADDR_FALL: prdata <= {24'h0, fallingCaptureValue};
                ADDR_RISE: prdata <= {24'h0, risingCaptureValue};
                ADDR_STOP: prdata <= {24'h0, moduleClockStopOne};
                ADDR_PORT: prdata <= {28'h0, timerIrqRequestFlag, timerIrqEnable,
                    noiseFilterEnable, capturePinFunction};
                default: prdata <= 32'h0;
            endcase
        end
    end

    a_wrap_flags: assert property (@(posedge clock) disable iff (!nrst) // R10
        wrap |=> overflowAtHighFlag || overflowAtLowFlag)
        else $error("wrap did not set an overflow flag");
    a_interval_low: assert property (@(posedge clock) disable iff (!nrst) // R10
        wrap && !capturePinFunction |=> overflowAtLowFlag && $stable(overflowAtHighFlag))
        else $error("interval wrap set wrong flag");
    a_capture_fall: assert property (@(posedge clock) disable iff (!nrst) // R05
        fallStrobe |=> fallingCaptureValue == $past(captureUpCounter))
        else $error("falling capture missed count");
    a_capture_rise: assert property (@(posedge clock) disable iff (!nrst) // R06
        riseStrobe |=> risingCaptureValue == $past(captureUpCounter))
        else $error("rising capture missed count");
    a_clear_count: assert property (@(posedge clock) disable iff (!nrst) // R13
        clearHit |=> captureUpCounter == 8'h00)
        else $error("clear edge did not clear counter");
    a_count_step: assert property (@(posedge clock) disable iff (!nrst) // R01
        countTick && !clearHit |=> captureUpCounter == $past(captureUpCounter) + 8'h01)
        else $error("counter did not step");
    a_standby_hold: assert property (@(posedge clock) disable iff (!nrst) // R15
        !active |=> $stable(captureUpCounter))
        else $error("counter moved in standby");
    a_ovf_irq: assert property (@(posedge clock) disable iff (!nrst) // R12
        wrap && overflowIrqEnable |=> timerIrqRequestFlag)
        else $error("overflow did not raise request");
    a_one_write: assert property (@(posedge clock) disable iff (!nrst) // R11
        wrMode && pwdata[OVF_HIGH_BIT] && overflowAtHighFlag |=> overflowAtHighFlag)
        else $error("writing one cleared flag");
    a_filter_primed: assert property (@(posedge clock) disable iff (!nrst) // R18
        !filtPrimed |-> !filtLevel)
        else $error("filter output high before priming");
    a_edge_irq: assert property (@(posedge clock) disable iff (!nrst) // R07
        capturePinFunction && (irqEdgeSelect ? fallStrobe : riseStrobe) |=> timerIrqRequestFlag)
        else $error("selected capture edge did not raise request");
    a_interval_clear: assert property (@(posedge clock) disable iff (!nrst) // R03
        !capturePinFunction |-> !clearHit)
        else $error("counter cleared by edge in interval mode");
    a_tick_edge: assert property (@(posedge clock) disable iff (!nrst) // R21
        countTick |-> $past(selClock) && !selClock)
        else $error("count tick without falling divided clock");
    a_standby_ctl: assert property (@(posedge clock) disable iff (!nrst) // R15
        wrMode && !active |=> $stable(clockSelect) && $stable(clearSel))
        else $error("mode field written in standby");
endmodule
`default_nettype wire

// ===== hdl/capture_timer_pkg.sv
// Constants for the 8-bit capture and interval timer.
// Assumes an APB slave with 32-bit data; registers take one aligned word.
package capture_timer_pkg;
    // Printed offsets are not all multiples of four, so they are word indices
    localparam logic [15:0] IDX_MODE = 16'hffbc;
    localparam logic [15:0] IDX_FALL = 16'hffbd;
    localparam logic [15:0] IDX_RISE = 16'hffbe;
    localparam logic [15:0] IDX_STOP = 16'hfffa;
    localparam logic [17:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [17:0] ADDR_FALL = {IDX_FALL, 2'b00};
    localparam logic [17:0] ADDR_RISE = {IDX_RISE, 2'b00};
    localparam logic [17:0] ADDR_STOP = {IDX_STOP, 2'b00};
    // Control bits that sit outside the printed map
    localparam logic [17:0] ADDR_PORT = 18'h00100;
    localparam int PORT_PIN_FUNC_BIT = 0;
    localparam int PORT_NOISE_BIT = 1;
    localparam int PORT_IRQ_EN_BIT = 2;
    localparam int PORT_IRQ_FLAG_BIT = 3;
    // Mode register fields, standby bit of the stop register, reset values
    localparam int OVF_HIGH_BIT = 7;
    localparam int OVF_LOW_BIT = 6;
    localparam int OVF_IE_BIT = 5;
    localparam int EDGE_SEL_BIT = 4;
    localparam int CLR_HI_BIT = 3;
    localparam int CLR_LO_BIT = 2;
    localparam int CKS_HI_BIT = 1;
    localparam int CKS_LO_BIT = 0;
    localparam int STANDBY_BIT = 3;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] STOP_RESET = 8'hff;
    localparam logic [7:0] CAPTURE_RESET = 8'h00;
    // Clock select encodings
    localparam logic [1:0] CKS_DIV64 = 2'h0;
    localparam logic [1:0] CKS_DIV32 = 2'h1;
    localparam logic [1:0] CKS_DIV2 = 2'h2;
    localparam logic [1:0] CKS_WATCH4 = 2'h3;
    // Counter clear encodings
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_FALL = 2'h1;
    localparam logic [1:0] CLR_RISE = 2'h2;
    localparam logic [1:0] CLR_BOTH = 2'h3;
    localparam int FILTER_STAGES = 5;
    localparam int PRESCALE_WIDTH = 6;
    localparam int WATCH_DIV_WIDTH = 2;
endpackage

// ===== hdl/noise_filter.sv
// Five-stage sampling filter on the capture input.
// Assumes the input is synchronous to clock; sampleEn is a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module noise_filter
    import capture_timer_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic sampleEn,
    input wire logic din,
    output logic dout,
    output logic primed
);
    logic [FILTER_STAGES-1:0] taps;

    // R16: shift and match
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            taps <= '1;
        end else if (sampleEn) begin
            taps <= {taps[FILTER_STAGES-2:0], din};
        end
    end

    // R18: output primed by five lows
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dout <= 1'b0;
            primed <= 1'b0;
        end else if (taps == '0) begin
            dout <= 1'b0;
            primed <= 1'b1;
        end else if (taps == '1 && primed) begin
            dout <= 1'b1;
        end
    end

    // R19: short high pulse kept out
    a_short_pulse: assert property (@(posedge clock) disable iff (!nrst)
        $rose(dout) |-> $past(taps[0]) && $past(taps[FILTER_STAGES-1])) // R19
        else $error("filter output rose without full agreement");
endmodule
`default_nettype wire

// ===== verification/pulse_source.sv
// Behavioural pulse source standing on the capture input pin.
// Assumes fire is a one-cycle request taken at a rising edge of clock.
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
    input wire logic clock,
    input wire logic nrst,
    input wire logic fire,
    input wire logic [7:0] width,
    input wire logic hold,
    output logic pin
);
    logic [7:0] left;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            left <= 8'h00;
        end else if (fire) begin
            left <= (width < 8'h02) ? 8'h02 : width;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end

    assign pin = hold | (left != 8'h00);
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the capture and interval timer.
// Assumes an APB slave answered through pready and a watch tick made here every second clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import capture_timer_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic watchTick = 1'b0;
    logic captureIn;
    logic timerIrq;
    logic fire = 1'b0;
    logic [7:0] width = 8'h00;
    logic hold = 1'b0;
    logic errSeen;
    logic [31:0] q;
    logic [31:0] rv;
    int badCount = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [31:0] A_MODE = {14'h0, ADDR_MODE};
    localparam logic [31:0] A_FALL = {14'h0, ADDR_FALL};
    localparam logic [31:0] A_RISE = {14'h0, ADDR_RISE};
    localparam logic [31:0] A_STOP = {14'h0, ADDR_STOP};
    localparam logic [31:0] A_PORT = {14'h0, ADDR_PORT};
    logic [7:0] wTab [4] = '{8'hc8, 8'hc8, 8'h28, 8'h50};
    logic [7:0] eTab [4] = '{8'h03, 8'h06, 8'h14, 8'h0a};

    capture_interval_timer8 uut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .watchTick(watchTick), .captureIn(captureIn),
        .timerIrq(timerIrq));
    pulse_source src (.clock(clock), .nrst(nrst), .fire(fire), .width(width), .hold(hold),
        .pin(captureIn));

    always #5 clock = ~clock;
    always @(posedge clock) watchTick <= ~watchTick;

    task automatic closeOut();
        if (badCount == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            closeOut();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        q = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, {24'h0, exp});
    endtask

    task automatic waitIrq(input int limit);
        int n;
        n = 0;
        @(posedge clock);
        while (timerIrq !== 1'b1 && n < limit) begin
            n++;
            @(posedge clock);
        end
    endtask

    task automatic pulse(input logic [7:0] w);
        @(posedge clock);
        fire <= 1'b1;
        width <= w;
        @(posedge clock);
        fire <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        rd(A_MODE, MODE_RESET);
        rd(A_FALL, CAPTURE_RESET);
        rd(A_RISE, CAPTURE_RESET);
        rd(A_STOP, STOP_RESET);
        apb(1'b1, A_STOP, 32'hf7);
        apb(1'b1, A_MODE, 32'h3c);
        rd(A_MODE, 8'h00);
        apb(1'b1, A_STOP, 32'hff);
        rd(32'h200, 8'h00);
        chk({31'h0, errSeen}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        // Interval mode overflow on the fast clock
        apb(1'b1, A_PORT, 32'h04);
        apb(1'b1, A_MODE, 32'h22);
        waitIrq(700);
        chk({31'h0, timerIrq}, 32'h1);
        rd(A_MODE, 8'h62);
        apb(1'b1, A_MODE, 32'h22);
        rd(A_MODE, 8'h22);
        apb(1'b1, A_MODE, 32'he2);
        rd(A_MODE, 8'h22);
        apb(1'b1, A_PORT, 32'h04);
        @(posedge clock);
        chk({31'h0, timerIrq}, 32'h0);
        // Pin function turned on while the pin is high
        hold <= 1'b1;
        apb(1'b1, A_PORT, 32'h05);
        repeat (5) @(posedge clock);
        chk({31'h0, timerIrq}, 32'h1);
        apb(1'b1, A_PORT, 32'h05);
        waitIrq(700);
        rd(A_MODE, 8'ha2);
        hold <= 1'b0;
        // Capture widths on every clock select and clear mode
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, A_MODE, {27'h0, i[0], i[1:0], i[1:0]});
            repeat (20) @(posedge clock);
            apb(1'b1, A_PORT, 32'h05);
            pulse(wTab[i]);
            repeat (wTab[i] / 2) @(posedge clock);
            chk({31'h0, timerIrq}, {31'h0, ~i[0]});
            repeat (wTab[i] / 2 + 10) @(posedge clock);
            chk({31'h0, timerIrq}, 32'h1);
            apb(1'b0, A_RISE, 32'h0);
            rv = q;
            apb(1'b0, A_FALL, 32'h0);
            rv = i[1] ? q : ((q - rv) & 32'hff);
            chk({31'h0, (rv + 1 >= eTab[i]) && (rv <= eTab[i] + 1)}, 32'h1);
        end
        // Filtered input on the fast sampling clock
        apb(1'b1, A_PORT, 32'h07);
        apb(1'b1, A_MODE, 32'h02);
        repeat (40) @(posedge clock);
        apb(1'b1, A_PORT, 32'h07);
        pulse(8'h06);
        repeat (40) @(posedge clock);
        chk({31'h0, timerIrq}, 32'h0);
        pulse(8'h1e);
        repeat (60) @(posedge clock);
        chk({31'h0, timerIrq}, 32'h1);
        closeOut();
    end
endmodule
`default_nettype wire
